// >>> hw/isaslt_top.sv
`timescale 1ns/1ps
`include "isaslt_regs.svh"
module isaslt_top
    import isaslt_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    // Board-side request port.
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic [1:0] REQ_KIND,
    input wire logic [23:0] REQ_ADDR,
    input wire logic [15:0] REQ_WDATA,
    input wire logic REQ_WIDE,
    output logic RSP_VALID,
    output logic [15:0] RSP_RDATA,
    output logic RSP_WIDE,
    input wire logic SOFT_RESET,
    input wire logic DMA_LOAD,
    input wire logic [23:0] DMA_ADDR_IN,
    input wire logic [23:0] DMA_COUNT_IN,
    output logic DMA_DONE,
    // Connector side.
    output logic BUS_CLK,
    output logic TIMER_OSC,
    output logic EXPANSION_RESET,
    output logic ADDR_ENABLE_DMA,
    output logic ADDR_LATCH_STROBE,
    output logic [6:0] LATCHABLE_UPPER_ADDR,
    output logic [19:0] SYSTEM_ADDR,
    output logic [15:0] SYSTEM_DATA_O,
    output logic SYSTEM_DATA_OE,
    input wire logic [15:0] SYSTEM_DATA_I,
    output logic HIGH_BYTE_ENABLE_N,
    output logic MEM_READ_N,
    output logic MEM_WRITE_N,
    output logic LOW_MEM_READ_N,
    output logic LOW_MEM_WRITE_N,
    output logic IO_READ_N,
    output logic IO_WRITE_N,
    input wire logic IO_WIDE_CAPABLE_N,
    input wire logic MEM_WIDE_CAPABLE_N,
    input wire logic ZERO_WAIT_N,
    output logic REFRESH_N_O,
    output logic REFRESH_N_OE,
    input wire logic REFRESH_N_I,
    input wire logic [7:0] DMA_REQ,
    output logic [7:0] DMA_ACK_N,
    output logic DMA_FINAL_COUNT_O,
    output logic DMA_FINAL_COUNT_OE,
    input wire logic DMA_FINAL_COUNT_I
);
    localparam int PIN_W = 29;
    localparam logic [8:0] REFRESH_CYC = 9'(`ISASLT_REFRESH_CYC);
    localparam logic [4:0] XRST_CYC = 5'(`ISASLT_XRST_CYC);

    logic [1:0] rst_sync_r;
    wire logic rst_n = rst_sync_r[1];

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    // Every connector input passes two flip-flops before use.
    logic [PIN_W-1:0] pin_meta_r;
    logic [PIN_W-1:0] pin_r;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_r <= {PIN_W{1'b1}};
            pin_r <= {PIN_W{1'b1}};
        end else begin
            pin_meta_r <= {SYSTEM_DATA_I, IO_WIDE_CAPABLE_N, MEM_WIDE_CAPABLE_N,
                ZERO_WAIT_N, REFRESH_N_I, ~DMA_FINAL_COUNT_I, ~DMA_REQ};
            pin_r <= pin_meta_r;
        end
    end
    wire logic [15:0] data_in = pin_r[28:13];
    wire logic io_wide = ~pin_r[12];
    wire logic mem_wide = ~pin_r[11];
    wire logic zero_wait = ~pin_r[10];
    wire logic refresh_ask = ~pin_r[9];
    wire logic final_in = ~pin_r[8];
    wire logic [7:0] dreq = ~pin_r[7:0];

    isaslt_clk_if ck ();
    isaslt_clkgen u_clkgen (
        .clk(CLK),
        .rst_n(rst_n),
        .ck(ck.gen)
    );
    wire logic tick = ck.bus_rise;

    function automatic logic [2:0] lowest_set(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : lowest_set

    function automatic logic below_1mb(input isaslt_addr_t a);
        return a[`ISASLT_LOW_MEM_HI:`ISASLT_LOW_MEM_LO] == 4'h0;
    endfunction : below_1mb

    isaslt_state_e state_r;
    logic hold_r;
    isaslt_kind_e hold_kind_r;
    isaslt_addr_t hold_addr_r;
    isaslt_data_t hold_wdata_r;
    logic hold_wide_r;
    logic [8:0] ref_tmr_r;
    logic ref_pend_r;
    logic [1:0] ref_oe_r;
    logic [7:0] ref_addr_r;
    logic dma_act_r;
    logic [2:0] dma_ch_r;
    isaslt_addr_t dma_addr_r;
    logic [23:0] dma_cnt_r;
    logic dma_last_r;
    logic [4:0] xrst_cnt_r;
    logic [2:0] wait_r;
    logic cyc_refresh_r;
    logic cyc_dma_r;
    logic cyc_wide_r;
    logic slave_wide_r;
    isaslt_kind_e cyc_kind_r;
    isaslt_addr_t cyc_addr_r;

    wire logic start_ref = state_r == ST_IDLE && tick && ref_pend_r;
    wire logic dma_go = dma_act_r && dreq[dma_ch_r];
    wire logic start_dma = state_r == ST_IDLE && tick && !ref_pend_r && dma_go;
    wire logic start_usr = state_r == ST_IDLE && tick && !ref_pend_r && !dma_go && hold_r;
    wire logic start_any = start_ref || start_dma || start_usr;
    wire logic cmd_end = state_r == ST_CMD && tick && (wait_r == 3'h0 || zero_wait);
    wire logic dma_stop = cmd_end && cyc_dma_r && (dma_last_r || final_in);
    wire logic is_io = cyc_kind_r == K_IO_RD || cyc_kind_r == K_IO_WR;
    wire logic is_rd = cyc_kind_r == K_MEM_RD || cyc_kind_r == K_IO_RD;
    wire logic is_wr = !is_rd;
    wire logic mem_side = !is_io || cyc_dma_r;
    wire logic strobe_on = state_r == ST_CMD;
    // A wide read takes lane 1 data only when the slave reports itself wide.
    wire logic got_wide = cyc_wide_r && (is_io ? io_wide : mem_wide);

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            wait_r <= 3'h0;
        end else begin
            unique case (state_r)
                ST_IDLE: if (start_any) state_r <= ST_ADDR;
                ST_ADDR: if (tick) begin
                    state_r <= ST_CMD;
                    wait_r <= cyc_wide_r ? `ISASLT_WAIT_WIDE : `ISASLT_WAIT_NARROW;
                end
                ST_CMD: if (cmd_end) state_r <= ST_DONE;
                    else if (tick) wait_r <= wait_r - 3'h1;
                ST_DONE: if (tick) state_r <= ST_IDLE;
            endcase
        end
    end

    // The cycle's address is frozen at its start and held until the next one.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cyc_kind_r <= K_MEM_RD;
            cyc_addr_r <= '0;
            cyc_refresh_r <= 1'b0;
            cyc_dma_r <= 1'b0;
            cyc_wide_r <= 1'b0;
        end else if (start_any) begin
            cyc_refresh_r <= start_ref;
            cyc_dma_r <= start_dma;
            cyc_kind_r <= start_ref ? K_MEM_RD : start_dma ? K_IO_RD : hold_kind_r;
            cyc_addr_r <= start_ref ? {16'h0, ref_addr_r} :
                start_dma ? dma_addr_r : hold_addr_r;
            cyc_wide_r <= start_usr && hold_wide_r;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            hold_r <= 1'b0;
            hold_kind_r <= K_MEM_RD;
            hold_addr_r <= '0;
            hold_wdata_r <= '0;
            hold_wide_r <= 1'b0;
            slave_wide_r <= 1'b0;
        end else begin
            if (REQ_VALID && REQ_READY) begin
                hold_r <= 1'b1;
                hold_kind_r <= isaslt_kind_e'(REQ_KIND);
                hold_addr_r <= REQ_ADDR;
                hold_wdata_r <= REQ_WDATA;
                hold_wide_r <= REQ_WIDE;
            end else if (start_usr) begin
                hold_r <= 1'b0;
            end
            if (state_r == ST_CMD) slave_wide_r <= got_wide;
        end
    end

    // Refresh: periodic timer or a master's request; a new request wins over the clear.
    // Our own refresh drive reaches the pin flops two clocks late, so that echo is ignored.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ref_tmr_r <= REFRESH_CYC;
            ref_pend_r <= 1'b0;
            ref_addr_r <= 8'h0;
            ref_oe_r <= 2'h0;
        end else begin
            ref_tmr_r <= (ref_tmr_r == 9'h0) ? REFRESH_CYC : ref_tmr_r - 9'h1;
            ref_oe_r <= {ref_oe_r[0], REFRESH_N_OE};
            if (ref_tmr_r == 9'h0 || (refresh_ask && !REFRESH_N_OE && ref_oe_r == 2'h0)) begin
                ref_pend_r <= 1'b1;
            end else if (start_ref) begin
                ref_pend_r <= 1'b0;
            end
            if (start_ref) ref_addr_r <= ref_addr_r + 8'h1;
        end
    end

    // One channel is served at a time; its acknowledge stays while it requests, until the final transfer ends it.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            dma_act_r <= 1'b0;
            dma_ch_r <= 3'h0;
            dma_addr_r <= '0;
            dma_cnt_r <= 24'h0;
            dma_last_r <= 1'b0;
        end else begin
            if (DMA_LOAD) begin
                dma_addr_r <= DMA_ADDR_IN;
                dma_cnt_r <= DMA_COUNT_IN;
            end else if (start_dma) begin
                dma_addr_r <= dma_addr_r + 24'h1;
                dma_cnt_r <= dma_cnt_r - 24'h1;
                dma_last_r <= dma_cnt_r == 24'h0;
            end
            if (dma_stop) begin
                dma_act_r <= 1'b0;
            end else if (state_r == ST_IDLE && dma_act_r && !dreq[dma_ch_r]) begin
                dma_act_r <= 1'b0;
            end else if (state_r == ST_IDLE && !dma_act_r && dreq != 8'h0) begin
                dma_act_r <= 1'b1;
                dma_ch_r <= lowest_set(dreq);
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            xrst_cnt_r <= XRST_CYC;
        end else if (SOFT_RESET) begin
            xrst_cnt_r <= XRST_CYC;
        end else if (xrst_cnt_r != 5'h0) begin
            xrst_cnt_r <= xrst_cnt_r - 5'h1;
        end
    end

    // Output flops.
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            REQ_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_RDATA <= 16'h0;
            RSP_WIDE <= 1'b0;
            DMA_DONE <= 1'b0;
            BUS_CLK <= 1'b0;
            TIMER_OSC <= 1'b0;
            EXPANSION_RESET <= 1'b1;
            ADDR_ENABLE_DMA <= 1'b0;
            ADDR_LATCH_STROBE <= 1'b0;
            LATCHABLE_UPPER_ADDR <= 7'h0;
            SYSTEM_ADDR <= 20'h0;
            SYSTEM_DATA_O <= 16'h0;
            SYSTEM_DATA_OE <= 1'b0;
            HIGH_BYTE_ENABLE_N <= 1'b1;
            MEM_READ_N <= 1'b1;
            MEM_WRITE_N <= 1'b1;
            LOW_MEM_READ_N <= 1'b1;
            LOW_MEM_WRITE_N <= 1'b1;
            IO_READ_N <= 1'b1;
            IO_WRITE_N <= 1'b1;
            REFRESH_N_O <= 1'b1;
            REFRESH_N_OE <= 1'b0;
            DMA_ACK_N <= 8'hff;
            DMA_FINAL_COUNT_O <= 1'b0;
            DMA_FINAL_COUNT_OE <= 1'b0;
        end else begin
            REQ_READY <= !hold_r && !(REQ_VALID && REQ_READY);
            RSP_VALID <= cmd_end && !cyc_refresh_r && !cyc_dma_r;
            if (cmd_end && is_rd) begin
                RSP_RDATA[`ISASLT_LANE0_HI:`ISASLT_LANE0_LO] <= data_in[7:0];
                RSP_RDATA[`ISASLT_LANE1_HI:`ISASLT_LANE1_LO] <=
                    slave_wide_r ? data_in[15:8] : 8'h0;
            end
            if (cmd_end) RSP_WIDE <= slave_wide_r;
            DMA_DONE <= dma_stop;
            BUS_CLK <= ck.bus_clk;
            TIMER_OSC <= ck.osc;
            EXPANSION_RESET <= xrst_cnt_r != 5'h0;
            ADDR_ENABLE_DMA <= state_r != ST_IDLE && cyc_dma_r;
            ADDR_LATCH_STROBE <= state_r == ST_ADDR && !tick;
            LATCHABLE_UPPER_ADDR <= cyc_addr_r[`ISASLT_UPPER_HI:`ISASLT_UPPER_LO];
            SYSTEM_ADDR <= cyc_addr_r[`ISASLT_SYS_HI:0];
            SYSTEM_DATA_O <= hold_wdata_r;
            SYSTEM_DATA_OE <= (state_r == ST_ADDR || state_r == ST_CMD) && is_wr && !cyc_dma_r;
            HIGH_BYTE_ENABLE_N <= !(state_r != ST_IDLE && cyc_wide_r);
            MEM_READ_N <= !(strobe_on && mem_side && is_rd && !cyc_dma_r);
            MEM_WRITE_N <= !(strobe_on && mem_side && (is_wr || cyc_dma_r));
            LOW_MEM_READ_N <= !(strobe_on && !is_io && is_rd
                && below_1mb(cyc_addr_r));
            LOW_MEM_WRITE_N <= !(strobe_on && mem_side && (is_wr || cyc_dma_r)
                && below_1mb(cyc_addr_r));
            IO_READ_N <= !(strobe_on && is_io && is_rd && !cyc_refresh_r);
            IO_WRITE_N <= !(strobe_on && is_io && is_wr && !cyc_dma_r);
            REFRESH_N_O <= 1'b0;
            REFRESH_N_OE <= state_r != ST_IDLE && cyc_refresh_r;
            DMA_ACK_N <= dma_act_r ? ~(8'h01 << dma_ch_r) : 8'hff;
            DMA_FINAL_COUNT_O <= 1'b1;
            DMA_FINAL_COUNT_OE <= strobe_on && cyc_dma_r && dma_last_r;
        end
    end
endmodule : isaslt_top

// >>> inc/isaslt_regs.svh
`ifndef ISASLT_REGS_SVH
`define ISASLT_REGS_SVH

// Clock rates in Hz.
`define ISASLT_SYS_HZ 64'd20000000
`define ISASLT_BUS_HZ 64'd8330000
`define ISASLT_OSC_HZ 64'd14318180

// Phase accumulator width and per-clock increments derived from the rates.
`define ISASLT_ACC_W 16
`define ISASLT_BUS_STEP ((`ISASLT_BUS_HZ << 16) / `ISASLT_SYS_HZ)
`define ISASLT_OSC_STEP ((`ISASLT_OSC_HZ << 16) / `ISASLT_SYS_HZ)

// Times in ns and their cycle counts at the system clock.
`define ISASLT_CLK_NS 50
`define ISASLT_REFRESH_NS 15000
`define ISASLT_REFRESH_CYC (`ISASLT_REFRESH_NS / `ISASLT_CLK_NS)
`define ISASLT_XRST_NS 1000
`define ISASLT_XRST_CYC ((`ISASLT_XRST_NS + `ISASLT_CLK_NS - 1) / `ISASLT_CLK_NS)

// Wait states after the first command bus clock, before an early end by the slave.
`define ISASLT_WAIT_WIDE 3'h1
`define ISASLT_WAIT_NARROW 3'h4

// Address field positions.
`define ISASLT_UPPER_HI 23
`define ISASLT_UPPER_LO 17
`define ISASLT_SYS_HI 19
`define ISASLT_LOW_MEM_HI 23
`define ISASLT_LOW_MEM_LO 20

// Lane layout of the data bus.
`define ISASLT_LANE1_HI 15
`define ISASLT_LANE1_LO 8
`define ISASLT_LANE0_HI 7
`define ISASLT_LANE0_LO 0

`endif

// >>> inc/isaslt_pkg.sv
package isaslt_pkg;

    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_DONE
    } isaslt_state_e;

    typedef enum logic [1:0] {
        K_MEM_RD,
        K_MEM_WR,
        K_IO_RD,
        K_IO_WR
    } isaslt_kind_e;

    typedef logic [23:0] isaslt_addr_t;
    typedef logic [15:0] isaslt_data_t;

endpackage : isaslt_pkg

// >>> inc/isaslt_clk_if.sv
`timescale 1ns/1ps
interface isaslt_clk_if;
    logic bus_clk;
    logic bus_rise;
    logic osc;

    modport gen (output bus_clk, output bus_rise, output osc);
    modport use_side (input bus_clk, input bus_rise, input osc);
endinterface : isaslt_clk_if

// >>> hw/isaslt_clkgen.sv
`timescale 1ns/1ps
`include "isaslt_regs.svh"
module isaslt_clkgen
    import isaslt_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    isaslt_clk_if.gen ck
);
    localparam logic [`ISASLT_ACC_W-1:0] BUS_STEP = `ISASLT_ACC_W'(`ISASLT_BUS_STEP);
    localparam logic [`ISASLT_ACC_W-1:0] OSC_STEP = `ISASLT_ACC_W'(`ISASLT_OSC_STEP);

    // Phase accumulators give the nominal average rate with one clock of jitter.
    // The timer oscillator lies above half the system rate, so its edges alias;
    // an exact 14.31818 MHz needs a faster source clock.
    logic [`ISASLT_ACC_W-1:0] bus_acc_r;
    logic [`ISASLT_ACC_W-1:0] osc_acc_r;
    logic bus_clk_r;
    logic bus_rise_r;
    logic osc_r;
    wire logic [`ISASLT_ACC_W-1:0] bus_acc_nxt = bus_acc_r + BUS_STEP;
    wire logic [`ISASLT_ACC_W-1:0] osc_acc_nxt = osc_acc_r + OSC_STEP;
    wire logic bus_msb_nxt = bus_acc_nxt[`ISASLT_ACC_W-1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_acc_r <= '0;
            osc_acc_r <= '0;
            bus_clk_r <= 1'b0;
            bus_rise_r <= 1'b0;
            osc_r <= 1'b0;
        end else begin
            bus_acc_r <= bus_acc_nxt;
            osc_acc_r <= osc_acc_nxt;
            bus_clk_r <= bus_msb_nxt;
            bus_rise_r <= bus_msb_nxt & ~bus_clk_r;
            osc_r <= osc_acc_nxt[`ISASLT_ACC_W-1];
        end
    end

    assign ck.bus_clk = bus_clk_r;
    assign ck.bus_rise = bus_rise_r;
    assign ck.osc = osc_r;
endmodule : isaslt_clkgen

// >>> test/isaslt_top_props.sv
`timescale 1ns/1ps
module isaslt_top_props
    import isaslt_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic SOFT_RESET,
    input wire logic BUS_CLK,
    input wire logic TIMER_OSC,
    input wire logic EXPANSION_RESET,
    input wire logic ADDR_ENABLE_DMA,
    input wire logic ADDR_LATCH_STROBE,
    input wire logic [6:0] LATCHABLE_UPPER_ADDR,
    input wire logic [19:0] SYSTEM_ADDR,
    input wire logic MEM_READ_N,
    input wire logic MEM_WRITE_N,
    input wire logic LOW_MEM_READ_N,
    input wire logic LOW_MEM_WRITE_N,
    input wire logic IO_READ_N,
    input wire logic IO_WRITE_N,
    input wire logic REFRESH_N_O,
    input wire logic REFRESH_N_OE,
    input wire logic [7:0] DMA_ACK_N,
    input wire logic DMA_FINAL_COUNT_O,
    input wire logic DMA_FINAL_COUNT_OE
);
    default clocking dcb @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    logic cmd_on;
    assign cmd_on = !(IO_READ_N && IO_WRITE_N && MEM_READ_N && MEM_WRITE_N);

    a_low_read_range: assert property (!LOW_MEM_READ_N |-> LATCHABLE_UPPER_ADDR[6:3] == 4'h0)
        else $error("low memory read strobe above the first megabyte");
    a_low_write_range: assert property (!LOW_MEM_WRITE_N |-> LATCHABLE_UPPER_ADDR[6:3] == 4'h0)
        else $error("low memory write strobe above the first megabyte");
    a_addr_held: assert property (cmd_on ##1 cmd_on |-> $stable(SYSTEM_ADDR))
        else $error("system address moved during a command");
    a_upper_at_latch: assert property ($fell(ADDR_LATCH_STROBE) |-> $stable(LATCHABLE_UPPER_ADDR))
        else $error("upper address changed at the latch strobe fall");
    a_bus_clk_runs: assert property ($rose(BUS_CLK) |-> ##[1:3] !BUS_CLK ##[1:3] BUS_CLK)
        else $error("bus clock stalled");
    a_osc_runs: assert property ($rose(TIMER_OSC) |-> ##[1:3] !TIMER_OSC ##[1:3] TIMER_OSC)
        else $error("timer oscillator stalled");
    a_xrst_release: assert property ($rose(NRST) |-> EXPANSION_RESET [*8])
        else $error("expansion reset ended too soon after reset");
    a_xrst_soft: assert property (SOFT_RESET |-> ##[1:5] EXPANSION_RESET)
        else $error("soft reset did not raise expansion reset");
    a_refresh_drive: assert property (REFRESH_N_OE |-> !REFRESH_N_O && IO_READ_N && IO_WRITE_N)
        else $error("refresh line driven wrongly");
    a_io_write_aen: assert property (!IO_WRITE_N |-> !ADDR_ENABLE_DMA)
        else $error("I/O write while address enable high");
    a_one_ack: assert property ($onehot0(~DMA_ACK_N))
        else $error("more than one DMA acknowledge");
    a_final_count: assert property (DMA_FINAL_COUNT_OE |-> DMA_FINAL_COUNT_O && DMA_ACK_N != 8'hff)
        else $error("final count outside a DMA transfer");
endmodule : isaslt_top_props

bind isaslt_top isaslt_top_props u_isaslt_top_props (
    .CLK(CLK), .NRST(NRST), .SOFT_RESET(SOFT_RESET), .BUS_CLK(BUS_CLK), .TIMER_OSC(TIMER_OSC),
    .EXPANSION_RESET(EXPANSION_RESET), .ADDR_ENABLE_DMA(ADDR_ENABLE_DMA),
    .ADDR_LATCH_STROBE(ADDR_LATCH_STROBE), .LATCHABLE_UPPER_ADDR(LATCHABLE_UPPER_ADDR),
    .SYSTEM_ADDR(SYSTEM_ADDR), .MEM_READ_N(MEM_READ_N), .MEM_WRITE_N(MEM_WRITE_N),
    .LOW_MEM_READ_N(LOW_MEM_READ_N), .LOW_MEM_WRITE_N(LOW_MEM_WRITE_N), .IO_READ_N(IO_READ_N),
    .IO_WRITE_N(IO_WRITE_N), .REFRESH_N_O(REFRESH_N_O), .REFRESH_N_OE(REFRESH_N_OE),
    .DMA_ACK_N(DMA_ACK_N), .DMA_FINAL_COUNT_O(DMA_FINAL_COUNT_O),
    .DMA_FINAL_COUNT_OE(DMA_FINAL_COUNT_OE));

// >>> test/isaslt_slave_model.sv
`timescale 1ns/1ps
module isaslt_slave_model (
    input wire logic clk,
    input wire logic addr_enable_dma,
    input wire logic ale,
    input wire logic hbe_n,
    input wire logic mem_rd_n,
    input wire logic mem_wr_n,
    input wire logic io_rd_n,
    input wire logic io_wr_n,
    input wire logic [15:0] wdata,
    input wire logic wdata_oe,
    input wire logic cfg_io_wide,
    input wire logic cfg_mem_wide,
    input wire logic cfg_zws,
    input wire logic [15:0] cfg_rdata,
    output logic [15:0] rdata,
    output logic io_wide_n,
    output logic mem_wide_n,
    output logic zero_wait_n,
    output logic [15:0] wr_seen
);
    logic io_sel;
    logic mem_sel;
    logic rd_sel;
    logic [15:0] last_r = 16'h0;
    // The I/O slave stays deaf while a DMA cycle holds address enable high.
    assign io_sel = !addr_enable_dma && !(io_rd_n && io_wr_n);
    assign mem_sel = !(mem_rd_n && mem_wr_n);
    assign rd_sel = (io_sel && !io_rd_n) || !mem_rd_n;
    assign io_wide_n = !(cfg_io_wide && (ale || io_sel));
    assign mem_wide_n = !(cfg_mem_wide && (ale || mem_sel));
    assign zero_wait_n = !(cfg_zws && (io_sel || mem_sel));
    // Released lanes flip every cycle, so stale data can never pass for a fresh read.
    assign rdata[15:8] = (rd_sel && !hbe_n) ? cfg_rdata[15:8] : ~last_r[15:8];
    assign rdata[7:0] = rd_sel ? cfg_rdata[7:0] : ~last_r[7:0];
    always @(posedge clk) begin
        last_r <= rdata;
        if (wdata_oe && ((io_sel && !io_wr_n) || !mem_wr_n)) begin
            wr_seen <= {hbe_n ? 8'h00 : wdata[15:8], wdata[7:0]};
        end
    end
endmodule : isaslt_slave_model

// >>> test/isaslt_tb_top.sv
`timescale 1ns/1ps
module isaslt_tb_top;
    import isaslt_pkg::*;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic REQ_VALID = 1'b0, REQ_WIDE = 1'b0, SOFT_RESET = 1'b0, DMA_LOAD = 1'b0;
    logic [1:0] REQ_KIND = 2'h0;
    logic [23:0] REQ_ADDR = 24'h0, DMA_ADDR_IN = 24'h0, DMA_COUNT_IN = 24'h0;
    logic [15:0] REQ_WDATA = 16'h0, cfg_rdata = 16'h0;
    logic [7:0] DMA_REQ = 8'h0;
    logic cfg_io_wide = 1'b0, cfg_mem_wide = 1'b0, cfg_zws = 1'b0, tb_ref_n = 1'b1, tb_tc = 1'b0;
    logic REQ_READY, RSP_VALID, RSP_WIDE, DMA_DONE, BUS_CLK, TIMER_OSC, EXPANSION_RESET;
    logic ADDR_ENABLE_DMA, ADDR_LATCH_STROBE, SYSTEM_DATA_OE, HIGH_BYTE_ENABLE_N;
    logic MEM_READ_N, MEM_WRITE_N, LOW_MEM_READ_N, LOW_MEM_WRITE_N, IO_READ_N, IO_WRITE_N;
    logic REFRESH_N_O, REFRESH_N_OE, DMA_FINAL_COUNT_O, DMA_FINAL_COUNT_OE;
    logic IO_WIDE_CAPABLE_N, MEM_WIDE_CAPABLE_N, ZERO_WAIT_N, saw_low, saw_tc;
    logic [15:0] RSP_RDATA, SYSTEM_DATA_O, mdl_rdata, wr_seen;
    logic [6:0] LATCHABLE_UPPER_ADDR;
    logic [19:0] SYSTEM_ADDR;
    logic [7:0] DMA_ACK_N;
    int fails = 0, checks_done = 0, cmd_len = 0, n_xfer = 0;
    // Shared lines: data is the driver's when enabled, refresh has a pull-up.
    wire [15:0] SYSTEM_DATA_I = SYSTEM_DATA_OE ? SYSTEM_DATA_O : mdl_rdata;
    wire REFRESH_N_I = (REFRESH_N_OE ? REFRESH_N_O : 1'b1) & tb_ref_n;
    wire DMA_FINAL_COUNT_I = (DMA_FINAL_COUNT_OE & DMA_FINAL_COUNT_O) | tb_tc;

    isaslt_top u_isaslt_top (.*);
    isaslt_slave_model u_isaslt_slave_model (
        .clk(CLK), .addr_enable_dma(ADDR_ENABLE_DMA), .ale(ADDR_LATCH_STROBE), .hbe_n(HIGH_BYTE_ENABLE_N),
        .mem_rd_n(MEM_READ_N), .mem_wr_n(MEM_WRITE_N), .io_rd_n(IO_READ_N), .io_wr_n(IO_WRITE_N),
        .wdata(SYSTEM_DATA_O), .wdata_oe(SYSTEM_DATA_OE), .cfg_io_wide(cfg_io_wide),
        .cfg_mem_wide(cfg_mem_wide), .cfg_zws(cfg_zws), .cfg_rdata(cfg_rdata), .rdata(mdl_rdata),
        .io_wide_n(IO_WIDE_CAPABLE_N), .mem_wide_n(MEM_WIDE_CAPABLE_N),
        .zero_wait_n(ZERO_WAIT_N), .wr_seen(wr_seen));

    always #25 CLK = ~CLK;

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // One user cycle; refresh and DMA cycles are kept out of the tallies.
    task automatic bus_op(input logic [1:0] k, input logic [23:0] a, input logic [15:0] d,
                          input logic w);
        int n = 0;
        @(posedge CLK);
        REQ_KIND <= k;
        REQ_ADDR <= a;
        REQ_WDATA <= d;
        REQ_WIDE <= w;
        REQ_VALID <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (REQ_READY !== 1'b1 && n < 400);
        REQ_VALID <= 1'b0;
        cmd_len = 0;
        saw_low = 1'b0;
        while (RSP_VALID !== 1'b1 && n < 800) begin
            @(posedge CLK);
            n++;
            if (REFRESH_N_OE !== 1'b1 && ADDR_ENABLE_DMA !== 1'b1) begin
                if ((IO_READ_N & IO_WRITE_N & MEM_READ_N & MEM_WRITE_N) === 1'b0) cmd_len++;
                if ((LOW_MEM_READ_N & LOW_MEM_WRITE_N) === 1'b0) saw_low = 1'b1;
            end
        end
        check("answer", n < 800, 1'b1);
    endtask : bus_op

    task automatic t_ext_reset;
        @(posedge CLK);
        check("xrst_held", EXPANSION_RESET, 1'b1);
        repeat (30) @(posedge CLK);
        check("xrst_end", EXPANSION_RESET, 1'b0);
        SOFT_RESET <= 1'b1;
        @(posedge CLK);
        SOFT_RESET <= 1'b0;
        repeat (5) @(posedge CLK);
        check("xrst_soft", EXPANSION_RESET, 1'b1);
        repeat (30) @(posedge CLK);
        check("xrst_soft_end", EXPANSION_RESET, 1'b0);
        $display("test ext_reset done");
    endtask : t_ext_reset

    task automatic t_mem_wide_read;
        cfg_mem_wide <= 1'b1;
        cfg_rdata <= 16'hbeef;
        bus_op(K_MEM_RD, 24'h004321, 16'h0000, 1'b1);
        check("mrd_data", RSP_RDATA, 16'hbeef);
        check("mrd_wide", RSP_WIDE, 1'b1);
        check("mrd_low", saw_low, 1'b1);
        cfg_mem_wide <= 1'b0;
        $display("test mem_wide_read done");
    endtask : t_mem_wide_read

    task automatic t_low_mem_edges;
        for (int i = 0; i < 4; i++) begin
            bus_op(i[0] ? K_MEM_WR : K_MEM_RD, i[1] ? 24'h100000 : 24'h0fffff, 16'h1357, 1'b0);
            check("low_mem", saw_low, !i[1]);
        end
        check("wr_lane0", wr_seen, 16'h0057);
        $display("test low_mem_edges done");
    endtask : t_low_mem_edges

    task automatic t_io_narrow_zws;
        int narrow;
        cfg_rdata <= 16'h7e81;
        bus_op(K_IO_RD, 24'h000300, 16'h0000, 1'b1);
        check("io_narrow", RSP_RDATA, 16'h0081);
        check("io_narrow_w", RSP_WIDE, 1'b0);
        bus_op(K_IO_RD, 24'h000301, 16'h0000, 1'b0);
        narrow = cmd_len;
        cfg_zws <= 1'b1;
        bus_op(K_IO_RD, 24'h000301, 16'h0000, 1'b0);
        check("zws_short", cmd_len < narrow, 1'b1);
        cfg_zws <= 1'b0;
        $display("test io_narrow_zws done");
    endtask : t_io_narrow_zws

    task automatic t_io_wide_write;
        cfg_io_wide <= 1'b1;
        bus_op(K_IO_WR, 24'h000302, 16'hc3a5, 1'b1);
        check("iow_data", wr_seen, 16'hc3a5);
        check("iow_wide", RSP_WIDE, 1'b1);
        cfg_io_wide <= 1'b0;
        $display("test io_wide_write done");
    endtask : t_io_wide_write

    task automatic dma_run(input logic [7:0] req, input logic [23:0] cnt, input logic early);
        logic prev = 1'b1;
        @(posedge CLK);
        DMA_ADDR_IN <= 24'h000200;
        DMA_COUNT_IN <= cnt;
        DMA_LOAD <= 1'b1;
        @(posedge CLK);
        DMA_LOAD <= 1'b0;
        DMA_REQ <= req;
        n_xfer = 0;
        saw_tc = 1'b0;
        for (int n = 0; n < 2000 && DMA_DONE !== 1'b1; n++) begin
            @(posedge CLK);
            if (DMA_ACK_N !== 8'hff) check("ack", DMA_ACK_N, 8'(~req));
            if (IO_READ_N === 1'b0 && prev === 1'b1 && ADDR_ENABLE_DMA === 1'b1) n_xfer++;
            prev = IO_READ_N;
            if (DMA_FINAL_COUNT_OE === 1'b1) saw_tc = 1'b1;
            if (early && n_xfer > 0) tb_tc <= 1'b1;
        end
        check("dma_done", DMA_DONE, 1'b1);
        tb_tc <= 1'b0;
        DMA_REQ <= 8'h00;
        repeat (8) @(posedge CLK);
        check("ack_off", DMA_ACK_N, 8'hff);
    endtask : dma_run

    task automatic t_dma_rollover;
        dma_run(8'h20, 24'h000001, 1'b0);
        check("dma_xfers", n_xfer, 2);
        check("dma_tc", saw_tc, 1'b1);
        $display("test dma_rollover done");
    endtask : t_dma_rollover

    task automatic t_dma_slave_end;
        dma_run(8'h02, 24'h00000f, 1'b1);
        check("dma_early", n_xfer <= 2, 1'b1);
        $display("test dma_slave_end done");
    endtask : t_dma_slave_end

    task automatic t_refresh_req;
        @(posedge CLK);
        tb_ref_n <= 1'b0;
        for (int n = 0; n < 60 && REFRESH_N_OE !== 1'b1; n++) @(posedge CLK);
        tb_ref_n <= 1'b1;
        check("refresh_on", REFRESH_N_OE, 1'b1);
        for (int n = 0; n < 40 && MEM_READ_N !== 1'b0; n++) @(posedge CLK);
        check("refresh_rd", MEM_READ_N, 1'b0);
        $display("test refresh_req done");
    endtask : t_refresh_req

    // The whole sequence needs a few hundred cycles; the limit leaves ample margin.
    initial begin
        #(20000 * 50);
        fails++;
        tally_and_finish();
    end

    initial begin
        repeat (16) @(posedge CLK);
        NRST <= 1'b1;
        t_ext_reset();
        t_mem_wide_read();
        t_low_mem_edges();
        t_io_narrow_zws();
        t_io_wide_write();
        t_dma_rollover();
        t_dma_slave_end();
        t_refresh_req();
        tally_and_finish();
    end
endmodule : isaslt_tb_top
